/* core/iox_pkg.sv */
// Shared constants and types for the two-wire expander link
package iox_pkg;
   localparam int CLK_PERIOD_NS = 10;
   localparam int SPIKE_NS = 50;
   localparam int SPIKE_CYC = (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Short link tick keeps runs brief; raise it for slow or long buses
   localparam int SCL_HALF_NS = 1000;
   localparam int SCL_HALF_CYC = SCL_HALF_NS / CLK_PERIOD_NS;
   localparam logic [3:0] FIXED_BASE = 4'h4;
   localparam logic [3:0] FIXED_ALT = 4'h7;
   localparam logic [6:0] GEN_CALL = 7'h00;
   localparam logic [7:0] PORT_RESET = 8'hFF;
   localparam logic [2:0] BIT_LAST = 3'h7;
   localparam int FIFO_DEPTH = 8;
   localparam int BYTE_W = 8;
   typedef enum logic [2:0] {
      IOX_IDLE, IOX_ADDR, IOX_AACK, IOX_WDATA, IOX_WACK, IOX_RDATA,
      IOX_RACK, IOX_IGNORE
   } iox_state_t;
   typedef enum logic [2:0] {
      IOXM_IDLE, IOXM_START, IOXM_BIT, IOXM_ACK, IOXM_STOP
   } iox_mstate_t;
endpackage

/* core/iox_bus_if.sv */
// Two-wire bus carrier: open-drain SDA is a wired-AND of both ends, SCL is driven by the controller only
interface iox_bus_if;
   logic scl_o;
   logic scl_oe;
   logic sda_o;
   logic sda_oe;
   logic sda_dev_o;
   logic sda_dev_oe;
   logic scl_line;
   logic sda_line;
   assign scl_line = !(scl_oe && !scl_o);
   assign sda_line = !((sda_oe && !sda_o) || (sda_dev_oe && !sda_dev_o));
   modport ctrl (output scl_o, scl_oe, sda_o, sda_oe, input scl_line, sda_line);
   modport dev (output sda_dev_o, sda_dev_oe, input scl_line, sda_line);
endinterface

/* core/iox_fifo.sv */
// Small synchronous FIFO with valid/ready on both sides
module iox_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_reg;
   logic [AW-1:0] rd_reg;
   logic [AW:0] cnt_reg;
   logic push;
   logic pop;
   assign in_ready = cnt_reg != (AW+1)'(DEPTH);
   assign out_valid = cnt_reg != '0;
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;
   assign out_data = mem[rd_reg];
   always_ff @(posedge core_clk) begin
      if (push) begin
         mem[wr_reg] <= in_data;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         wr_reg <= '0;
         rd_reg <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) begin
            wr_reg <= AW'((32'(wr_reg) + 1) % DEPTH);
         end
         if (pop) begin
            rd_reg <= AW'((32'(rd_reg) + 1) % DEPTH);
         end
         cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule

/* core/iox_target.sv */
// Target end: bus front end with address match and port latch
module iox_target
   import iox_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   iox_bus_if.dev bus,
   input wire logic variant_alt,
   input wire logic strap_address_pin_low,
   input wire logic strap_address_pin_mid,
   input wire logic strap_address_pin_high,
   input wire logic [7:0] port_in,
   output logic [7:0] port_out,
   output logic port_write_pulse,
   output logic port_read_pulse,
   output logic [7:0] rx_data,
   output logic rx_valid,
   input wire logic rx_ready
);
   logic [1:0] scl_sync_reg;
   logic [1:0] sda_sync_reg;
   logic scl_f_reg;
   logic sda_f_reg;
   logic scl_prev_reg;
   logic sda_prev_reg;
   logic [3:0] scl_cnt_reg;
   logic [3:0] sda_cnt_reg;
   logic [2:0] strap_meta_reg;
   logic [2:0] strap_reg;
   logic variant_meta_reg;
   logic variant_reg;
   logic [7:0] port_meta_reg;
   logic [7:0] port_sync_reg;
   logic ack_reg;
   iox_state_t state_reg;
   logic [2:0] bit_reg;
   logic [7:0] sh_reg;
   logic [7:0] tx_reg;
   logic sda_drv_reg;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic addr_hit;
   logic [7:0] byte_in;

   // Deglitch: a level must persist SPIKE_CYC cycles to be taken
   function automatic logic [3:0] iox_cnt_step(input logic [3:0] c,
                                               input logic diff);
      iox_cnt_step = diff ? c + 4'h1 : 4'h0;
   endfunction

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_sync_reg <= 2'h3;
         sda_sync_reg <= 2'h3;
      end else begin
         scl_sync_reg <= {scl_sync_reg[0], bus.scl_line};
         sda_sync_reg <= {sda_sync_reg[0], bus.sda_line};
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_cnt_reg <= 4'h0;
         sda_cnt_reg <= 4'h0;
      end else begin
         scl_cnt_reg <= iox_cnt_step(scl_cnt_reg, scl_sync_reg[1] != scl_f_reg);
         sda_cnt_reg <= iox_cnt_step(sda_cnt_reg, sda_sync_reg[1] != sda_f_reg);
         if (32'(scl_cnt_reg) >= SPIKE_CYC - 1
             && scl_sync_reg[1] != scl_f_reg) begin
            scl_f_reg <= scl_sync_reg[1];
            scl_cnt_reg <= 4'h0;
         end
         if (32'(sda_cnt_reg) >= SPIKE_CYC - 1
             && sda_sync_reg[1] != sda_f_reg) begin
            sda_f_reg <= sda_sync_reg[1];
            sda_cnt_reg <= 4'h0;
         end
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_prev_reg <= 1'b1;
         sda_prev_reg <= 1'b1;
      end else begin
         scl_prev_reg <= scl_f_reg;
         sda_prev_reg <= sda_f_reg;
      end
   end

   // Straps and port pins are asynchronous: two flops before any use
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         strap_meta_reg <= 3'h0;
         strap_reg <= 3'h0;
         variant_meta_reg <= 1'b0;
         variant_reg <= 1'b0;
         port_meta_reg <= PORT_RESET;
         port_sync_reg <= PORT_RESET;
      end else begin
         strap_meta_reg <= {strap_address_pin_high, strap_address_pin_mid,
                            strap_address_pin_low};
         strap_reg <= strap_meta_reg;
         variant_meta_reg <= variant_alt;
         variant_reg <= variant_meta_reg;
         port_meta_reg <= port_in;
         port_sync_reg <= port_meta_reg;
      end
   end

   assign scl_rise = scl_f_reg && !scl_prev_reg;
   assign scl_fall = !scl_f_reg && scl_prev_reg;
   assign start_det = scl_f_reg && scl_prev_reg && sda_prev_reg
                      && !sda_f_reg;
   assign stop_det = scl_f_reg && scl_prev_reg && !sda_prev_reg
                     && sda_f_reg;
   assign byte_in = {sh_reg[6:0], sda_f_reg};
   assign addr_hit = byte_in[7:1] != GEN_CALL
      && byte_in[7:4] == (variant_reg ? FIXED_ALT : FIXED_BASE)
      && byte_in[3:1] == strap_reg;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= IOX_IDLE;
         bit_reg <= 3'h0;
         sh_reg <= 8'h00;
      end else if (stop_det) begin
         state_reg <= IOX_IDLE;
      end else if (start_det) begin
         state_reg <= IOX_ADDR;
         bit_reg <= 3'h0;
      end else begin
         unique case (state_reg)
            IOX_IDLE, IOX_IGNORE: begin
            end
            IOX_ADDR, IOX_WDATA: begin
               if (scl_rise) begin
                  sh_reg <= byte_in;
                  bit_reg <= bit_reg + 3'h1;
                  if (bit_reg == BIT_LAST) begin
                     if (state_reg == IOX_WDATA) begin
                        state_reg <= IOX_WACK;
                     end else if (addr_hit) begin
                        state_reg <= IOX_AACK;
                     end else begin
                        state_reg <= IOX_IGNORE;
                     end
                  end
               end
            end
            IOX_AACK, IOX_WACK: begin
               if (scl_fall && ack_reg) begin
                  // Leave the ack slot; direction came from address LSB
                  state_reg <= (state_reg == IOX_AACK && sh_reg[0])
                               ? IOX_RDATA : IOX_WDATA;
                  bit_reg <= 3'h0;
               end
            end
            IOX_RDATA: begin
               if (scl_fall) begin
                  bit_reg <= bit_reg + 3'h1;
                  if (bit_reg == BIT_LAST) begin
                     state_reg <= IOX_RACK;
                  end
               end
            end
            IOX_RACK: begin
               if (scl_rise) begin
                  // NACK ends output until START or STOP
                  state_reg <= sda_f_reg ? IOX_IGNORE : IOX_RACK;
               end else if (scl_fall) begin
                  state_reg <= IOX_RDATA;
                  bit_reg <= 3'h0;
               end
            end
         endcase
      end
   end

   // SDA drive: ack during ack slot, data bits in read; changes on SCL low
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sda_drv_reg <= 1'b0;
      end else if (start_det || stop_det) begin
         sda_drv_reg <= 1'b0;
      end else if (scl_fall) begin
         sda_drv_reg <= 1'b0;
         if (state_reg == IOX_AACK && sh_reg[0] && ack_reg) begin
            sda_drv_reg <= !port_sync_reg[7];
         end else if (state_reg == IOX_RDATA && bit_reg != BIT_LAST) begin
            sda_drv_reg <= !tx_reg[3'h6 - bit_reg];
         end else if (state_reg == IOX_RACK) begin
            sda_drv_reg <= !port_sync_reg[7];
         end
      end
   end

   // Ack pull-down from the fall after bit eight to the next fall
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         ack_reg <= 1'b0;
      end else if (start_det || stop_det) begin
         ack_reg <= 1'b0;
      end else if (scl_fall) begin
         ack_reg <= !ack_reg
                    && (state_reg == IOX_AACK || state_reg == IOX_WACK);
      end
   end

   // Port latch, read snapshot and received-byte stream
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         port_out <= PORT_RESET;
         tx_reg <= 8'h00;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         port_write_pulse <= 1'b0;
         port_read_pulse <= 1'b0;
      end else begin
         port_write_pulse <= 1'b0;
         port_read_pulse <= 1'b0;
         if (rx_valid && rx_ready) begin
            rx_valid <= 1'b0;
         end
         if (scl_fall && ack_reg && state_reg == IOX_WACK) begin
            port_out <= sh_reg;
            rx_data <= sh_reg;
            rx_valid <= 1'b1;
            port_write_pulse <= 1'b1;
         end
         if (scl_fall && ((state_reg == IOX_AACK && sh_reg[0] && ack_reg)
                          || state_reg == IOX_RACK)) begin
            tx_reg <= port_sync_reg;
            port_read_pulse <= 1'b1;
         end
      end
   end

   assign bus.sda_dev_o = 1'b0;
   assign bus.sda_dev_oe = ack_reg || sda_drv_reg;
endmodule

/* core/iox_ctrl.sv */
// Controller end: SCL divider, byte sequencer and FIFO-fed write stream
module iox_ctrl
   import iox_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   iox_bus_if.ctrl bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [6:0] cmd_addr,
   input wire logic cmd_read,
   input wire logic [7:0] cmd_count,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic rd_valid,
   output logic nack_seen,
   output logic busy
);
   iox_mstate_t st_reg;
   logic [15:0] tick_reg;
   logic phase_reg;
   logic [3:0] bit_reg;
   logic [7:0] sh_reg;
   logic [7:0] left_reg;
   logic rd_reg;
   logic addr_ph_reg;
   logic scl_reg;
   logic sda_reg;
   logic [1:0] sda_sync_reg;
   logic f_valid;
   logic f_pop;
   logic [7:0] f_data;
   logic tick;
   logic ack_end;
   logic nack;
   logic done;
   logic load_next;

   iox_fifo #(.WIDTH(BYTE_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .core_clk(core_clk), .sys_rst(sys_rst),
      .in_valid(wr_valid), .in_ready(wr_ready), .in_data(wr_data),
      .out_valid(f_valid), .out_ready(f_pop), .out_data(f_data));

   assign tick = 32'(tick_reg) >= SCL_HALF_CYC - 1;
   // A full tick of idle bus must pass before the next START
   assign cmd_ready = st_reg == IOXM_IDLE && sda_sync_reg[1] && tick;
   assign busy = st_reg != IOXM_IDLE;
   assign ack_end = tick && scl_reg && st_reg == IOXM_ACK;
   assign nack = sda_sync_reg[1] && (addr_ph_reg || !rd_reg);
   assign done = addr_ph_reg ? left_reg == 8'h00 : left_reg <= 8'h01;
   // Write stream ends early if the FIFO is empty at the ack slot end
   assign load_next = ack_end && !nack && !done && (rd_reg || f_valid);
   assign f_pop = load_next && !rd_reg;
   assign bus.scl_o = scl_reg;
   assign bus.scl_oe = !scl_reg;
   assign bus.sda_o = sda_reg;
   assign bus.sda_oe = !sda_reg;

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         sda_sync_reg <= 2'h3;
      end else begin
         sda_sync_reg <= {sda_sync_reg[0], bus.sda_line};
      end
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_reg <= IOXM_IDLE;
         tick_reg <= 16'h0000;
         phase_reg <= 1'b0;
         bit_reg <= 4'h0;
         sh_reg <= 8'h00;
         left_reg <= 8'h00;
         rd_reg <= 1'b0;
         addr_ph_reg <= 1'b0;
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
         rd_data <= 8'h00;
         rd_valid <= 1'b0;
         nack_seen <= 1'b0;
      end else begin
         rd_valid <= 1'b0;
         tick_reg <= tick ? 16'h0000 : tick_reg + 16'h0001;
         unique case (st_reg)
            IOXM_IDLE: begin
               tick_reg <= tick ? tick_reg : tick_reg + 16'h0001;
               if (cmd_valid && cmd_ready) begin
                  tick_reg <= 16'h0000;
                  st_reg <= IOXM_START;
                  sh_reg <= {cmd_addr, cmd_read};
                  rd_reg <= cmd_read;
                  left_reg <= cmd_count;
                  addr_ph_reg <= 1'b1;
                  nack_seen <= 1'b0;
                  sda_reg <= 1'b0;
               end
            end
            IOXM_START: begin
               if (tick) begin
                  scl_reg <= 1'b0;
                  st_reg <= IOXM_BIT;
                  bit_reg <= 4'h0;
                  phase_reg <= 1'b0;
               end
            end
            // Each bit: two ticks low (data moves in the first), one high
            IOXM_BIT: begin
               if (tick) begin
                  if (scl_reg) begin
                     scl_reg <= 1'b0;
                     sh_reg <= {sh_reg[6:0], sda_sync_reg[1]};
                     bit_reg <= bit_reg + 4'h1;
                     if (bit_reg == 4'h7) begin
                        st_reg <= IOXM_ACK;
                     end
                  end else if (!phase_reg) begin
                     sda_reg <= (rd_reg && !addr_ph_reg) ? 1'b1
                                : sh_reg[7];
                     phase_reg <= 1'b1;
                  end else begin
                     scl_reg <= 1'b1;
                     phase_reg <= 1'b0;
                  end
               end
            end
            IOXM_ACK: begin
               if (tick) begin
                  if (scl_reg) begin
                     scl_reg <= 1'b0;
                     if (nack) begin
                        nack_seen <= 1'b1;
                        st_reg <= IOXM_STOP;
                     end else if (load_next) begin
                        if (!addr_ph_reg) begin
                           left_reg <= left_reg - 8'h01;
                        end
                        addr_ph_reg <= 1'b0;
                        sh_reg <= rd_reg ? 8'hFF : f_data;
                        bit_reg <= 4'h0;
                        st_reg <= IOXM_BIT;
                     end else begin
                        st_reg <= IOXM_STOP;
                     end
                  end else if (!phase_reg) begin
                     // Master acks read bytes it wants continued
                     sda_reg <= (rd_reg && !addr_ph_reg)
                                ? (left_reg <= 8'h01) : 1'b1;
                     if (rd_reg && !addr_ph_reg) begin
                        rd_data <= sh_reg;
                        rd_valid <= 1'b1;
                     end
                     phase_reg <= 1'b1;
                  end else begin
                     scl_reg <= 1'b1;
                     phase_reg <= 1'b0;
                  end
               end
            end
            IOXM_STOP: begin
               if (tick) begin
                  phase_reg <= !phase_reg;
                  if (!phase_reg) begin
                     if (!scl_reg) begin
                        sda_reg <= 1'b0;
                     end else begin
                        sda_reg <= 1'b1;
                        st_reg <= IOXM_IDLE;
                     end
                  end else begin
                     scl_reg <= 1'b1;
                  end
               end
            end
         endcase
      end
   end
endmodule

/* test/iox_link_monitor.sv */
// Wire-level checker for the joined two-wire link
module iox_link_monitor (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic sda_dev_oe,
   input wire logic scl_line,
   input wire logic sda_line
);
   timeunit 1ns;
   timeprecision 100ps;
   logic scl_reg;
   logic sda_reg;
   logic [3:0] bit_reg;
   logic [7:0] shift_reg;
   logic data_reg;
   logic wr_dir_reg;
   logic acked_reg;
   logic nack_reg;
   logic start;
   logic stop;
   logic rise;
   logic ack_rise;
   assign start = scl_line && scl_reg && sda_reg && !sda_line;
   assign stop = scl_line && scl_reg && !sda_reg && sda_line;
   assign rise = scl_line && !scl_reg;
   assign ack_rise = rise && bit_reg == 4'h8;
   default clocking mon_cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         scl_reg <= 1'b1;
         sda_reg <= 1'b1;
      end else begin
         scl_reg <= scl_line;
         sda_reg <= sda_line;
      end
   end
   // Slot 8 is the acknowledge bit; cleared at the fall that ends it
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         bit_reg <= 4'h0;
      end else if (start || stop) begin
         bit_reg <= 4'h0;
      end else if (rise) begin
         bit_reg <= bit_reg + 4'h1;
      end else if (!scl_line && scl_reg && bit_reg == 4'h9) begin
         bit_reg <= 4'h0;
      end
   end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         shift_reg <= 8'h00;
      end else if (rise && bit_reg < 4'h8) begin
         shift_reg <= {shift_reg[6:0], sda_line};
      end
   end
   // Frame bookkeeping: address phase, direction, address ack, read end
   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         data_reg <= 1'b0;
         wr_dir_reg <= 1'b1;
         acked_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else if (start || stop) begin
         data_reg <= 1'b0;
         nack_reg <= 1'b0;
      end else if (ack_rise && !data_reg) begin
         data_reg <= 1'b1;
         wr_dir_reg <= !shift_reg[0];
         acked_reg <= !sda_line;
      end else if (ack_rise && !wr_dir_reg && sda_line) begin
         nack_reg <= 1'b1;
      end
   end
   a_dev_moves_low: assert property ($changed(sda_dev_oe) |-> !scl_line)
      else $error("target data drive changed while clock high");
   a_start_quiet: assert property (start |-> !sda_dev_oe)
      else $error("target driving data at start");
   a_stop_quiet: assert property (stop |-> !sda_dev_oe [*8])
      else $error("target driving data after stop");
   a_start_idle: assert property (
      start |-> $past(scl_line, 2) && $past(sda_line, 2))
      else $error("start issued on a busy bus");
   a_gen_call_ignored: assert property (
      ack_rise && !data_reg && shift_reg[7:1] == 7'h00 |-> !sda_dev_oe)
      else $error("general call acknowledged");
   a_write_ack_held: assert property (
      ack_rise && data_reg && wr_dir_reg && acked_reg |-> sda_dev_oe [*8])
      else $error("written byte not acknowledged");
   a_read_released: assert property (
      ack_rise && data_reg && !wr_dir_reg |-> !sda_dev_oe)
      else $error("target holds data in read acknowledge slot");
   a_nack_released: assert property (nack_reg |-> !sda_dev_oe)
      else $error("target drives data after read end");
   a_filter_lag: assert property (
      $fell(scl_line) |-> $stable(sda_dev_oe) [*4])
      else $error("target reacted faster than input filter");
endmodule

/* test/iox_bench.sv */
// Bench: controller and target ends joined on one two-wire link
module iox_bench;
   import iox_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic variant_alt, rx_ready, rx_valid, wr_pulse, rd_pulse, cmd_valid;
   logic cmd_ready, cmd_read, wr_valid, wr_ready, rd_valid, nack_seen, busy;
   logic [2:0] strap;
   logic [6:0] cmd_addr, my_addr;
   logic [6:0] bad[3];
   logic [7:0] port_in, port_out, rx_data, rd_data, wr_data, cmd_count;
   logic [7:0] rxq[$], rdq[$], wq[$];
   int failures = 0, checks_done = 0, wr_cnt = 0, rd_cnt = 0, n, m;
   iox_bus_if bus();
   iox_ctrl i_iox_ctrl (.core_clk(core_clk), .sys_rst(sys_rst), .bus(bus),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_addr(cmd_addr),
      .cmd_read(cmd_read), .cmd_count(cmd_count), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_data(rd_data),
      .rd_valid(rd_valid), .nack_seen(nack_seen), .busy(busy));
   iox_target i_iox_target (.core_clk(core_clk), .sys_rst(sys_rst),
      .bus(bus), .variant_alt(variant_alt),
      .strap_address_pin_low(strap[0]), .strap_address_pin_mid(strap[1]),
      .strap_address_pin_high(strap[2]), .port_in(port_in),
      .port_out(port_out), .port_write_pulse(wr_pulse),
      .port_read_pulse(rd_pulse), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready));
   iox_link_monitor i_iox_link_monitor (.core_clk(core_clk),
      .sys_rst(sys_rst), .sda_dev_oe(bus.sda_dev_oe),
      .scl_line(bus.scl_line), .sda_line(bus.sda_line));
   always #5 core_clk = ~core_clk;
   // Receive side stalls at random; the byte copy must wait for it
   always @(posedge core_clk) #1 rx_ready = 1'($urandom);
   always @(posedge core_clk) begin
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rx_data);
      if (rd_valid === 1'b1) rdq.push_back(rd_data);
      if (wr_pulse === 1'b1) wr_cnt++;
      if (rd_pulse === 1'b1) rd_cnt++;
   end
   task automatic wrap_up();
      if (failures == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic tick();
      @(posedge core_clk);
      #1;
   endtask
   // Issue one command and wait for the link to go idle again
   task automatic xfer(input logic [6:0] a, input logic rd, input int cnt);
      int k;
      cmd_addr = a;
      cmd_read = rd;
      cmd_count = 8'(cnt);
      cmd_valid = 1'b1;
      k = 0;
      do begin
         @(posedge core_clk);
         k++;
      end while (cmd_ready !== 1'b1 && k < 1000);
      #1;
      cmd_valid = 1'b0;
      k = 0;
      do begin
         tick();
         k++;
      end while (busy !== 1'b0 && k < 40000);
   endtask
   initial begin
      void'($urandom(29453));
      {variant_alt, strap} = 4'($urandom);
      port_in = 8'($urandom);
      {rx_ready, cmd_valid, cmd_read, wr_valid} = 4'h0;
      {cmd_addr, cmd_count, wr_data} = 23'h0;
      repeat (8) @(posedge core_clk);
      #1;
      sys_rst = 1'b0;
      check(port_out, PORT_RESET);
      check({7'h00, bus.sda_line}, 8'h01);
      my_addr = {variant_alt ? FIXED_ALT : FIXED_BASE, strap};
      // Fill the write buffer until it refuses, then send it in one frame
      repeat (FIFO_DEPTH) wq.push_back(8'($urandom));
      wr_valid = 1'b1;
      n = 0;
      repeat (12) begin
         wr_data = n < FIFO_DEPTH ? wq[n] : 8'h00;
         @(posedge core_clk);
         if (wr_ready === 1'b1) n++;
         #1;
      end
      wr_valid = 1'b0;
      check(8'(n), 8'(FIFO_DEPTH));
      check({7'h00, wr_ready}, 8'h00);
      xfer(my_addr, 1'b0, FIFO_DEPTH);
      check({7'h00, wr_ready}, 8'h01);
      check({7'h00, nack_seen}, 8'h00);
      check(port_out, wq[FIFO_DEPTH-1]);
      check(8'(rxq.size()), 8'(FIFO_DEPTH));
      foreach (rxq[i]) check(rxq[i], wq[i]);
      xfer(my_addr, 1'b1, 2);
      check({7'h00, nack_seen}, 8'h00);
      check(8'(rdq.size()), 8'h02);
      foreach (rdq[i]) check(rdq[i], port_in);
      check(8'(rd_cnt), 8'h02);
      // Wrong strap bit, wrong variant bits, general call: all refused
      bad = '{my_addr ^ (7'h01 << ($urandom % 3)), my_addr ^ 7'h18, 7'h00};
      foreach (bad[i]) begin
         xfer(bad[i], 1'b0, 0);
         check({7'h00, nack_seen}, 8'h01);
      end
      // Empty buffer: the write frame ends right after the address
      xfer(my_addr, 1'b0, 3);
      check({7'h00, nack_seen}, 8'h00);
      check(8'(wr_cnt), 8'(FIFO_DEPTH));
      check(8'(rxq.size()), 8'(FIFO_DEPTH));
      wrap_up();
   end
   initial begin
      #800000;
      failures++;
      wrap_up();
   end
endmodule
